// *** verilog/ptecl_consts.vh ***
/*
 holds offsets, field positions and reset values of the port t slice.
 assumes byte addresses on a 32-bit axi4-lite bus, one word per register.
*/
`ifndef PTECL_CONSTS_VH
`define PTECL_CONSTS_VH
`define PTECL_ADDR_W 12
`define PTECL_OFF_PORT_T_DATA 12'h240
`define PTECL_OFF_CLK_CTL 12'h248
`define PTECL_OFF_IRQ_CTL 12'h24c
`define PTECL_OFF_DIR 12'h250
`define PTECL_OFF_ALT 12'h254
`define PTECL_OFF_INPUT 12'h258
`define PTECL_OFF_MODE 12'h25c
`define PTECL_CLK_DIS_BIT 7
`define PTECL_EXTRA_SIXTEEN_DIVIDE_BIT 5
`define PTECL_IRQ_EDGE_BIT 7
`define PTECL_IRQ_CONN_BIT 6
`define PTECL_NONMASKABLE_INTERRUPT_PIN_CONN_BIT 5
`define PTECL_RST_CLK_CTL 8'h80
`define PTECL_RST_IRQ_CTL 8'h40
`define PTECL_RST_PORT 8'h00
`define PTECL_RESP_OKAY 2'b00
`define PTECL_RESP_SLVERR 2'b10
`endif

// *** verilog/ptecl_clkgen.v ***
/*
 free-running clock output generator: divide by div+1 (by 2 when div is 0 and /16 is off), optional /16.
 assumes the bus clock is aclk; restart pulse comes from the register side.
*/
`timescale 1ns/1ps
module ptecl_clkgen #(
    parameter DIV_W = 5
) (
    input wire aclk, // bus clock
    input wire aresetn, // sync reset, active low
    input wire restart, // settings changed
    input wire disable_out, // output off
    input wire extra_sixteen_divide_en, // extra /16 stage
    input wire [DIV_W-1:0] div_val, // divide by value+1, by 2 for value 0 without /16
    output reg clk_out // free clock output
);
    reg [DIV_W-1:0] cnt_r;
    reg [3:0] sub_r;
    wire [DIV_W:0] n = {1'b0, div_val} + {{DIV_W{1'b0}}, 1'b1};
    wire base_tick = (cnt_r == div_val);
    // base clock high for first half of each period
    wire [DIV_W:0] hi_cnt = (n + {{DIV_W{1'b0}}, 1'b1}) >> 1;
    wire base_lvl = ({1'b0, cnt_r} < hi_cnt);
    always @(posedge aclk)
    begin
        if (!aresetn || restart)
        begin
            cnt_r <= {DIV_W{1'b0}};
            sub_r <= 4'h0;
        end
        else
        begin
            cnt_r <= base_tick ? {DIV_W{1'b0}} : cnt_r + 1'b1;
            if (base_tick)
                sub_r <= sub_r + 4'h1;
        end
    end
    always @(posedge aclk)
    begin
        if (!aresetn || disable_out)
            clk_out <= 1'b0;
        else if (extra_sixteen_divide_en)
            clk_out <= ~sub_r[3];
        else if (div_val == {DIV_W{1'b0}})
            clk_out <= ~clk_out;
        else
            clk_out <= base_lvl;
    end
endmodule // ptecl_clkgen

// *** verilog/ptecl_top.v ***
/*
 port t data, clock output control and interrupt pin control over axi4-lite.
 assumes single clock aclk; pins synchronous; special_mode strap stable.
*/
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ptecl_consts.vh"
module ptecl_top #(
    parameter PORT_W = 8,
    parameter DIV_W = 5
) (
    input wire aclk, // bus clock
    input wire aresetn, // sync reset, active low
    input wire [11:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid, // write address valid
    output wire s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // write strobes
    input wire s_axi_wvalid, // write data valid
    output wire s_axi_wready, // write data ready
    output reg [1:0] s_axi_bresp, // write response
    output reg s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [11:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output wire s_axi_arready, // read address ready
    output reg [31:0] s_axi_rdata, // read data
    output reg [1:0] s_axi_rresp, // read response
    output reg s_axi_rvalid, // read valid
    input wire s_axi_rready, // read ready
    input wire special_mode, // high in special mode
    input wire [PORT_W-1:0] port_t_in, // pin input levels
    output reg [PORT_W-1:0] port_t_out, // pin output levels
    output reg [PORT_W-1:0] port_t_oe, // pin output enables
    output reg [PORT_W-1:0] port_t_ie, // pin input buffer enables
    input wire [PORT_W-1:0] seg_en, // display segment enables
    input wire [PORT_W-1:0] seg_out, // display segment levels
    input wire [PORT_W-1:0] tmr_oc_en, // timer output channel enables
    input wire [PORT_W-1:0] tmr_oc_out, // timer output levels
    input wire irq_pin_n, // maskable interrupt pin
    input wire nonmaskable_interrupt_pin, // nonmaskable pin, low active
    input wire irq_ack, // interrupt serviced pulse
    output wire irq_request, // maskable request to controller
    output wire nonmaskable_interrupt_pin_request, // nonmaskable request to controller
    output wire free_clock_output // divided bus clock
);
    reg [PORT_W-1:0] port_t_data_r;
    reg [PORT_W-1:0] port_t_direction_r;
    reg [PORT_W-1:0] sync1_r;
    reg [PORT_W-1:0] port_t_input_image_r;
    reg [7:0] clock_output_control_r;
    reg [7:0] interrupt_pin_control_r;
    reg edge_written_r;
    reg xconn_written_r;
    reg irq_pin_d_r;
    reg irq_edge_r;
    reg clk_restart_r;
    reg [11:0] awaddr_r;
    reg aw_held_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg w_held_r;
    integer i;

    // one-hot write response states
    localparam [1:0] WR_IDLE = 2'b01;
    localparam [1:0] WR_RESP = 2'b10;
    reg [1:0] wr_state_r;

    // true when address is one of the implemented registers
    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `PTECL_OFF_PORT_T_DATA) ||
                     (a == `PTECL_OFF_CLK_CTL) ||
                     (a == `PTECL_OFF_IRQ_CTL) ||
                     (a == `PTECL_OFF_DIR) ||
                     (a == `PTECL_OFF_ALT) ||
                     (a == `PTECL_OFF_INPUT) ||
                     (a == `PTECL_OFF_MODE);
        end
    endfunction

    assign s_axi_awready = !aw_held_r && (wr_state_r == WR_IDLE);
    assign s_axi_wready = !w_held_r && (wr_state_r == WR_IDLE);
    assign s_axi_arready = !s_axi_rvalid;

    wire aw_go = s_axi_awvalid && s_axi_awready;
    wire w_go = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held_r || aw_go;
    wire w_have = w_held_r || w_go;
    wire [11:0] wa = aw_held_r ? awaddr_r : s_axi_awaddr;
    wire [31:0] wd = w_held_r ? wdata_r : s_axi_wdata;
    wire [3:0] ws = w_held_r ? wstrb_r : s_axi_wstrb;
    wire do_wr = (wr_state_r == WR_IDLE) && aw_have && w_have;
    wire wr_lane0 = do_wr && ws[0];
    wire [11:0] wa_w = {wa[11:2], 2'b00};

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_state_r <= WR_IDLE;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PTECL_RESP_OKAY;
        end
        else
        begin
            if (aw_go)
                awaddr_r <= s_axi_awaddr;
            if (w_go)
            begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            case (wr_state_r)
                WR_IDLE:
                begin
                    if (do_wr)
                    begin
                        aw_held_r <= 1'b0;
                        w_held_r <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= mapped(wa_w) ? `PTECL_RESP_OKAY :
                                       `PTECL_RESP_SLVERR;
                        wr_state_r <= WR_RESP;
                    end
                    else
                    begin
                        aw_held_r <= aw_have;
                        w_held_r <= w_have;
                    end
                end
                WR_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        s_axi_bvalid <= 1'b0;
                        wr_state_r <= WR_IDLE;
                    end
                end
                default:
                    wr_state_r <= WR_IDLE;
            endcase
        end
    end

    // register stores; write-once fields lock in normal mode
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port_t_data_r <= `PTECL_RST_PORT;
            port_t_direction_r <= `PTECL_RST_PORT;
            clock_output_control_r <= `PTECL_RST_CLK_CTL;
            interrupt_pin_control_r <= `PTECL_RST_IRQ_CTL;
            edge_written_r <= 1'b0;
            xconn_written_r <= 1'b0;
            clk_restart_r <= 1'b0;
        end
        else
        begin
            clk_restart_r <= 1'b0;
            if (wr_lane0 && wa_w == `PTECL_OFF_PORT_T_DATA)
                port_t_data_r <= wd[PORT_W-1:0];
            if (wr_lane0 && wa_w == `PTECL_OFF_DIR)
                port_t_direction_r <= wd[PORT_W-1:0];
            if (wr_lane0 && wa_w == `PTECL_OFF_CLK_CTL)
            begin
                // bits 6 reserved, kept zero
                clock_output_control_r <= wd[7:0] & 8'hbf;
                clk_restart_r <= 1'b1;
            end
            if (wr_lane0 && wa_w == `PTECL_OFF_IRQ_CTL)
            begin
                interrupt_pin_control_r[`PTECL_IRQ_CONN_BIT] <=
                    wd[`PTECL_IRQ_CONN_BIT];
                if (special_mode || !edge_written_r)
                begin
                    interrupt_pin_control_r[`PTECL_IRQ_EDGE_BIT] <=
                        wd[`PTECL_IRQ_EDGE_BIT];
                    edge_written_r <= 1'b1;
                end
                if (special_mode || !xconn_written_r)
                begin
                    interrupt_pin_control_r[`PTECL_NONMASKABLE_INTERRUPT_PIN_CONN_BIT] <=
                        wd[`PTECL_NONMASKABLE_INTERRUPT_PIN_CONN_BIT];
                    xconn_written_r <= 1'b1;
                end
            end
        end
    end

    // pin input synchroniser, two stages
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_r <= `PTECL_RST_PORT;
            port_t_input_image_r <= `PTECL_RST_PORT;
        end
        else
        begin
            sync1_r <= port_t_in;
            port_t_input_image_r <= sync1_r;
        end
    end

    // pin multiplexing: segment, then timer, then gpio
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port_t_out <= `PTECL_RST_PORT;
            port_t_oe <= `PTECL_RST_PORT;
            port_t_ie <= `PTECL_RST_PORT;
        end
        else
        begin
            for (i = 0; i < PORT_W; i = i + 1)
            begin
                if (seg_en[i])
                begin
                    port_t_out[i] <= seg_out[i];
                    port_t_oe[i] <= 1'b0;
                    port_t_ie[i] <= 1'b0;
                end
                else if (tmr_oc_en[i])
                begin
                    port_t_out[i] <= tmr_oc_out[i];
                    port_t_oe[i] <= 1'b1;
                    port_t_ie[i] <= 1'b1;
                end
                else
                begin
                    port_t_out[i] <= port_t_data_r[i];
                    port_t_oe[i] <= port_t_direction_r[i];
                    port_t_ie[i] <= 1'b1;
                end
            end
        end
    end

    // interrupt pin sensing
    wire irq_conn = interrupt_pin_control_r[`PTECL_IRQ_CONN_BIT];
    wire irq_edge_mode = interrupt_pin_control_r[`PTECL_IRQ_EDGE_BIT];
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_pin_d_r <= 1'b1;
            irq_edge_r <= 1'b0;
        end
        else
        begin
            irq_pin_d_r <= irq_pin_n;
            if (irq_edge_mode && irq_pin_d_r && !irq_pin_n)
                irq_edge_r <= 1'b1;
            else if (irq_ack)
                irq_edge_r <= 1'b0;
        end
    end
    assign irq_request = irq_conn &&
        (irq_edge_mode ? irq_edge_r : !irq_pin_n);
    assign nonmaskable_interrupt_pin_request =
        interrupt_pin_control_r[`PTECL_NONMASKABLE_INTERRUPT_PIN_CONN_BIT] &&
        !nonmaskable_interrupt_pin;

    // read channel
    wire [11:0] ra = {s_axi_araddr[11:2], 2'b00};
    wire [PORT_W-1:0] data_view = (port_t_direction_r & port_t_data_r) |
        (~port_t_direction_r & port_t_input_image_r);
    reg [31:0] rd_val;
    always @*
    begin
        rd_val = 32'h00000000;
        case (ra)
            `PTECL_OFF_PORT_T_DATA: rd_val[PORT_W-1:0] = data_view;
            `PTECL_OFF_CLK_CTL: rd_val[7:0] = clock_output_control_r;
            `PTECL_OFF_IRQ_CTL: rd_val[7:0] = interrupt_pin_control_r;
            `PTECL_OFF_DIR: rd_val[PORT_W-1:0] = port_t_direction_r;
            `PTECL_OFF_ALT: rd_val[PORT_W-1:0] = seg_en | tmr_oc_en;
            `PTECL_OFF_INPUT: rd_val[PORT_W-1:0] = port_t_input_image_r;
            `PTECL_OFF_MODE: rd_val[0] = special_mode;
            default: rd_val = 32'h00000000;
        endcase
    end
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PTECL_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= mapped(ra) ? `PTECL_RESP_OKAY :
                           `PTECL_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    ptecl_clkgen #(
        .DIV_W(DIV_W)
    ) u_clkgen (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(clk_restart_r),
        .disable_out(clock_output_control_r[`PTECL_CLK_DIS_BIT]),
        .extra_sixteen_divide_en(clock_output_control_r[`PTECL_EXTRA_SIXTEEN_DIVIDE_BIT]),
        .div_val(clock_output_control_r[DIV_W-1:0]),
        .clk_out(free_clock_output)
    );
endmodule // ptecl_top

// *** verif/ptecl_pins.sv ***
/*
 board model of the port t pins: drives the wire where the slice does not.
 assumes the bench moves the board levels every scenario.
*/
`timescale 1ns/1ps
module ptecl_pins (
    input wire [7:0] port_t_out, // slice levels
    input wire [7:0] port_t_oe, // slice drives
    input wire [7:0] ext_lvl, // board levels
    output wire [7:0] port_t_in // wire levels
);
    assign port_t_in = (port_t_oe & port_t_out) | (~port_t_oe & ext_lvl);
endmodule // ptecl_pins

// *** verif/ptecl_chk.sv ***
/*
 assertions on the ports of ptecl_top.
 assumes one clock aclk and a synchronous low reset.
*/
`timescale 1ns/1ps
module ptecl_chk #(
    parameter PORT_W = 8
) (
    input wire aclk, // clock
    input wire aresetn, // reset
    input wire s_axi_awvalid, // aw
    input wire s_axi_awready, // aw
    input wire s_axi_wvalid, // w
    input wire s_axi_wready, // w
    input wire [1:0] s_axi_bresp, // b
    input wire s_axi_bvalid, // b
    input wire s_axi_bready, // b
    input wire s_axi_arvalid, // ar
    input wire s_axi_arready, // ar
    input wire [31:0] s_axi_rdata, // r
    input wire [1:0] s_axi_rresp, // r
    input wire s_axi_rvalid, // r
    input wire s_axi_rready, // r
    input wire [PORT_W-1:0] port_t_out, // pin
    input wire [PORT_W-1:0] port_t_oe, // pin
    input wire [PORT_W-1:0] port_t_ie, // pin
    input wire [PORT_W-1:0] seg_en, // alt
    input wire [PORT_W-1:0] tmr_oc_en, // alt
    input wire [PORT_W-1:0] tmr_oc_out // alt
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_seg_off: assert property (
        ($past(seg_en) & (port_t_oe | port_t_ie)) == 0)
        else $error("segment pin buffer on");
    a_tmr_drive: assert property ($past(aresetn) |->
        ($past(tmr_oc_en & ~seg_en) & ~port_t_oe) == 0 &&
        ($past(tmr_oc_en & ~seg_en) &
        (port_t_out ^ $past(tmr_oc_out))) == 0)
        else $error("timer channel not on pin");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response dropped");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_aw_block: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_err_zero: assert property (
        s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 0)
        else $error("reserved read not zero");
    c_r_stall: cover property (s_axi_rvalid && !s_axi_rready);
    c_b_err: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
    c_tmr: cover property (|(tmr_oc_en & ~seg_en));
endmodule // ptecl_chk
bind ptecl_top ptecl_chk #(.PORT_W(PORT_W)) u_chk (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .port_t_out(port_t_out), .port_t_oe(port_t_oe), .port_t_ie(port_t_ie),
    .seg_en(seg_en), .tmr_oc_en(tmr_oc_en), .tmr_oc_out(tmr_oc_out));

// *** verif/ptecl_top_bench.sv ***
/*
 self-checking bench of ptecl_top: axi4-lite master, pins and irq pins.
 assumes ptecl_consts.vh on the include path and the board pin model.
*/
`timescale 1ns/1ps
`include "ptecl_consts.vh"
module ptecl_top_bench;
    localparam [39:0] CODES = 40'h01021f2024;
    reg aclk = 1'b0, aresetn = 1'b0, fco_q = 1'b0;
    reg [11:0] awaddr = 12'h0, araddr = 12'h0;
    reg [31:0] wdata = 32'h0, seed = 32'hfaa9061c;
    reg [3:0] wstrb = 4'hf;
    reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    reg special_mode = 0, irq_pin_n = 1, xpin_n = 1, irq_ack = 0;
    reg [7:0] seg_en = 0, seg_out = 0, tmr_en = 0, tmr_out = 0, ext = 0;
    reg [7:0] v, s, t, d, c, m, e;
    wire awready, wready, bvalid, arready, rvalid, irq_req, nonmaskable_interrupt_pin_req, fco;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] pin_in, pin_out, pin_oe, pin_ie;
    reg [33:0] rq[$];
    reg [1:0] bq[$];
    integer error_cnt = 0, n_tests = 0, i, p, n;
    ptecl_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .special_mode(special_mode), .port_t_in(pin_in),
        .port_t_out(pin_out), .port_t_oe(pin_oe), .port_t_ie(pin_ie),
        .seg_en(seg_en), .seg_out(seg_out), .tmr_oc_en(tmr_en),
        .tmr_oc_out(tmr_out), .irq_pin_n(irq_pin_n),
        .nonmaskable_interrupt_pin(xpin_n), .irq_ack(irq_ack),
        .irq_request(irq_req), .nonmaskable_interrupt_pin_request(nonmaskable_interrupt_pin_req),
        .free_clock_output(fco));
    ptecl_pins u_pins (.port_t_out(pin_out), .port_t_oe(pin_oe),
        .ext_lvl(ext), .port_t_in(pin_in));
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) fco_q <= fco;
    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task cmp(input [79:0] nm, input [33:0] ex, input [33:0] g);
        begin
            n_tests = n_tests + 1;
            if (g !== ex)
            begin
                error_cnt = error_cnt + 1;
                $display("unexpected %0s: expected %h, seen %h", nm, ex, g);
            end
        end
    endtask
    always @(posedge aclk)
    begin
        if (rvalid && rready)
            cmp("read", rq.pop_front(), {rresp, rdata});
        if (bvalid && bready)
            cmp("bresp", bq.pop_front(), bresp);
    end
    task wr(input [11:0] a, input [31:0] dd, input [1:0] r);
        reg pa, pw;
        begin
            bq.push_back(r);
            @(posedge aclk);
            awaddr <= a;
            wdata <= dd;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            pa = 1;
            pw = 1;
            while (pa | pw)
            begin
                @(posedge aclk);
                if (pa && awready) pa = 0;
                if (pw && wready) pw = 0;
                awvalid <= pa;
                wvalid <= pw;
            end
            // one stall cycle on the response
            @(posedge aclk);
            bready <= 1'b1;
            do @(posedge aclk); while (!bvalid);
            bready <= 1'b0;
        end
    endtask
    task rd(input [11:0] a, input [31:0] ex, input [1:0] r);
        begin
            rq.push_back({r, ex});
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            do @(posedge aclk); while (!arready);
            arvalid <= 1'b0;
            @(posedge aclk);
            rready <= 1'b1;
            do @(posedge aclk); while (!rvalid);
            rready <= 1'b0;
        end
    endtask
    task cyc(input integer k);
        repeat (k) @(posedge aclk);
    endtask
    task close_out;
        begin
            $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
            if (error_cnt == 0 && n_tests > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // about forty times the expected run
    initial
    begin
        #100000;
        error_cnt = error_cnt + 1;
        close_out;
    end
    initial
    begin
        cyc(3);
        aresetn <= 1'b1;
        rd(`PTECL_OFF_CLK_CTL, 32'h80, 2'b00);
        rd(`PTECL_OFF_IRQ_CTL, 32'h40, 2'b00);
        cmp("clk idle", 1'b0, fco);
        rd(12'h244, 32'h0, `PTECL_RESP_SLVERR);
        wr(12'h244, 32'hff, `PTECL_RESP_SLVERR);
        rd(12'h244, 32'h0, `PTECL_RESP_SLVERR);
        seed = lfsr(seed);
        v = seed[7:0];
        wr(`PTECL_OFF_DIR, 32'hff, 2'b00);
        wr(`PTECL_OFF_PORT_T_DATA, v, 2'b00);
        cyc(2);
        cmp("pin out", v, pin_out);
        rd(`PTECL_OFF_PORT_T_DATA, v, 2'b00);
        // lane 0 strobe low: the data register keeps its value
        wstrb <= 4'h0;
        wr(`PTECL_OFF_PORT_T_DATA, ~v, 2'b00);
        wstrb <= 4'hf;
        rd(`PTECL_OFF_PORT_T_DATA, v, 2'b00);
        v = ~v;
        ext <= v;
        wr(`PTECL_OFF_DIR, 32'h0, 2'b00);
        cyc(2);
        rd(`PTECL_OFF_PORT_T_DATA, v, 2'b00);
        rd(`PTECL_OFF_INPUT, v, 2'b00);
        for (i = 0; i < 4; i = i + 1)
        begin
            seed = lfsr(seed);
            d = i[0] ? 8'hff : 8'h00;
            v = seed[7:0] ^ seed[31:24];
            wr(`PTECL_OFF_DIR, d, 2'b00);
            wr(`PTECL_OFF_PORT_T_DATA, v, 2'b00);
            seg_en <= seed[15:8] & seed[7:0];
            tmr_en <= seed[23:16];
            tmr_out <= seed[31:24];
            seg_out <= seed[7:0];
            ext <= seed[15:8];
            cyc(2);
            s = seg_en;
            t = tmr_en;
            m = ~s & (t | d);
            cmp("oe", m, pin_oe);
            e = ~s;
            cmp("ie", e, pin_ie);
            e = ((t & tmr_out) | (~t & v)) & m;
            cmp("out", e, pin_out & m);
            rd(`PTECL_OFF_ALT, s | t, 2'b00);
        end
        seg_en <= 8'h0;
        tmr_en <= 8'h0;
        for (i = 0; i < 5; i = i + 1)
        begin
            c = CODES[8*i +: 8];
            wr(`PTECL_OFF_CLK_CTL, c, 2'b00);
            rd(`PTECL_OFF_CLK_CTL, c, 2'b00);
            p = (c[4:0] + 1) * (c[5] ? 16 : 1);
            do @(posedge aclk); while (!(fco && !fco_q));
            n = 0;
            do
            begin
                @(posedge aclk);
                n = n + 1;
            end
            while (!(fco && !fco_q));
            cmp("period", p, n);
        end
        wr(`PTECL_OFF_CLK_CTL, 32'h85, 2'b00);
        cyc(3);
        p = 0;
        repeat (40) @(posedge aclk) p = p | fco;
        cmp("clk off", 0, p);
        irq_pin_n <= 1'b0;
        cyc(4);
        cmp("irq level", 1'b1, irq_req);
        irq_pin_n <= 1'b1;
        cyc(4);
        cmp("irq level", 1'b0, irq_req);
        wr(`PTECL_OFF_IRQ_CTL, 32'he0, 2'b00);
        rd(`PTECL_OFF_IRQ_CTL, 32'he0, 2'b00);
        irq_pin_n <= 1'b0;
        cyc(2);
        irq_pin_n <= 1'b1;
        cyc(4);
        cmp("irq edge", 1'b1, irq_req);
        irq_ack <= 1'b1;
        cyc(1);
        irq_ack <= 1'b0;
        cyc(2);
        cmp("irq ack", 1'b0, irq_req);
        xpin_n <= 1'b0;
        cyc(4);
        cmp("nonmaskable_interrupt_pin on", 1'b1, nonmaskable_interrupt_pin_req);
        xpin_n <= 1'b1;
        wr(`PTECL_OFF_IRQ_CTL, 32'h0, 2'b00);
        rd(`PTECL_OFF_IRQ_CTL, 32'ha0, 2'b00);
        irq_pin_n <= 1'b0;
        cyc(4);
        cmp("irq off", 1'b0, irq_req);
        irq_pin_n <= 1'b1;
        special_mode <= 1'b1;
        wr(`PTECL_OFF_IRQ_CTL, 32'h40, 2'b00);
        rd(`PTECL_OFF_IRQ_CTL, 32'h40, 2'b00);
        rd(`PTECL_OFF_MODE, 32'h1, 2'b00);
        xpin_n <= 1'b0;
        cyc(4);
        cmp("nonmaskable_interrupt_pin off", 1'b0, nonmaskable_interrupt_pin_req);
        cyc(2);
        close_out;
    end
endmodule // ptecl_top_bench
